//--- pkg/art_pkg.sv
// constants and types shared by the auto-reload timer files
package art_pkg;
    // ------------------------------------------------------------
    // register offsets on the core data bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'hD5;
    localparam logic [7:0] ADDR_FLAGS = 8'hD6;
    localparam logic [7:0] ADDR_CFG = 8'hD7;
    localparam logic [7:0] ADDR_RELOAD = 8'hD9;
    localparam logic [7:0] ADDR_COMPARE = 8'hDA;
    localparam logic [7:0] ADDR_LOAD_PORT = 8'hDB;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MC_LOAD_STROBE = 7;
    localparam int MC_COUNT_EN = 6;
    localparam int MC_PWM_OE = 5;
    localparam int MC_EDGE_IE = 4;
    localparam int MC_MATCH_IE = 3;
    localparam int MC_WRAP_IE = 2;
    localparam int FL_EDGE = 2;
    localparam int FL_MATCH = 1;
    localparam int FL_WRAP = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [6:0] MODE_RESET = 7'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [6:0] PSC_CLEAR = 7'h00;
    localparam logic [1:0] DIV3_LAST = 2'h2;

    // ------------------------------------------------------------
    // mode and source encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ART_AUTO_RELOAD = 2'h0,
        ART_CAPTURE = 2'h1,
        ART_CAPTURE_RESET = 2'h2,
        ART_EXT_LOAD = 2'h3
    } art_mode_type;

    typedef enum logic [1:0] {
        ART_SRC_INT = 2'h0,
        ART_SRC_INT_DIV3 = 2'h1,
        ART_SRC_PIN = 2'h2,
        ART_SRC_NONE = 2'h3
    } art_src_type;
endpackage

//--- src/art_pin_sync.sv
// two-stage synchroniser and edge detector for the timer input pin
`timescale 1ns/10ps
module art_pin_sync
    import art_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // pin and detected edges
    input wire logic pin_in,
    output logic rise_out,
    output logic fall_out
);
    logic meta;
    logic sync;
    logic last;

    // meta is read by sync alone, edges come from the later stages
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else if (clk_en_in) begin
            meta <= pin_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise_out = sync & ~last;
    assign fall_out = ~sync & last;
endmodule

//--- src/art_timer.sv
// auto-reload timer: registers, prescaler, counter, flags and waveform pin
//
// Notes on behaviour
// - every counter load clears the prescaler
// - writing 06h clears wrap, keeps edge flag
// - mode register readable, writable, resets to 00h
// - load strobe copies reload value, reads zero
// - count enable low freezes prescaler and counter
// - waveform enable drives timer output pin
// - edge request when enable and flag set
// - match request when enable and flag set
// - wrap request when enable and flag set
// - mode field picks one of four modes
// - flags clear by writing zero only
// - active input edge sets capture edge flag
// - counter equal compare sets match flag
// - rollover FFh to 00h sets wrap flag
// - prescale field selects divide by 2^n
// - edge select enables rising or falling
// - clock source field routes prescaler input
// - load port reads and writes live counter
// - auto-reload reloads on wrap, drives pin
// - capture mode copies counter on edge
// - capture-reset also clears counter and prescaler
// - external-load mode loads counter on edge
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module art_timer
    import art_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // pins
    input wire logic timer_input_pin_in,
    output logic timer_output_pin_out,
    output logic timer_output_pin_oe_out,
    // interrupt requests
    output logic edge_irq_out,
    output logic match_irq_out,
    output logic wrap_irq_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [6:0] mode_control;
    logic [2:0] event_flags;
    logic [7:0] clock_edge_prescale_config;
    logic [7:0] reload_capture_value;
    logic [7:0] compare_value;
    logic [7:0] counter_core;
    logic [6:0] prescaler_stage;
    logic [1:0] div3_count;
    logic pwm_level;
    logic [7:0] next_counter;
    logic [6:0] next_prescaler;
    logic [2:0] next_flags;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_mode;
    logic wr_flags;
    logic wr_cfg;
    logic wr_reload;
    logic wr_compare;
    logic wr_lport;
    logic load_strobe;
    logic pin_rise;
    logic pin_fall;
    logic ext_edge;
    logic ext_load;
    logic cap_reset;
    logic capture;
    logic src_tick;
    logic count_tick;
    logic [6:0] ps_mask;
    logic cnt_step;
    logic any_load;
    logic step_taken;
    logic wrap_evt;
    logic match_evt;
    art_mode_type opmode;
    art_src_type src_sel;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = clk_en_in & wr_in & (a == off);
    endfunction

    assign wr_mode = hit(addr_in, ADDR_MODE);
    assign wr_flags = hit(addr_in, ADDR_FLAGS);
    assign wr_cfg = hit(addr_in, ADDR_CFG);
    assign wr_reload = hit(addr_in, ADDR_RELOAD);
    assign wr_compare = hit(addr_in, ADDR_COMPARE);
    assign wr_lport = hit(addr_in, ADDR_LOAD_PORT);
    assign load_strobe = wr_mode & wdata_in[MC_LOAD_STROBE];

    assign opmode = art_mode_type'(mode_control[1:0]);
    assign src_sel = art_src_type'(clock_edge_prescale_config[1:0]);

    // ------------------------------------------------------------
    // input pin
    // ------------------------------------------------------------
    art_pin_sync u_pin_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .pin_in(timer_input_pin_in),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // low select bit enables, high select bit picks falling
    assign ext_edge = clk_en_in & clock_edge_prescale_config[2]
        & (clock_edge_prescale_config[3] ? pin_fall : pin_rise);
    assign ext_load = ext_edge & (opmode == ART_EXT_LOAD);
    assign cap_reset = ext_edge & (opmode == ART_CAPTURE_RESET);
    assign capture = ext_edge & (opmode == ART_CAPTURE || opmode == ART_CAPTURE_RESET);

    // ------------------------------------------------------------
    // clock source and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div3_count <= 2'h0;
        end else if (clk_en_in) begin
            div3_count <= (div3_count == DIV3_LAST) ? 2'h0 : div3_count + 2'h1;
        end
    end

    // pin source counts rising pin edges; the pin is sampled, so it must be slow
    always_comb begin
        unique case (src_sel)
            ART_SRC_INT: src_tick = 1'b1;
            ART_SRC_INT_DIV3: src_tick = (div3_count == DIV3_LAST);
            ART_SRC_PIN: src_tick = pin_rise;
            ART_SRC_NONE: src_tick = 1'b0;
        endcase
    end

    assign count_tick = clk_en_in & mode_control[MC_COUNT_EN] & src_tick;
    assign ps_mask = 7'((8'h01 << clock_edge_prescale_config[7:5]) - 8'h01);
    assign cnt_step = count_tick & ((prescaler_stage & ps_mask) == ps_mask);

    assign any_load = wr_lport | load_strobe | ext_load | cap_reset;
    assign step_taken = cnt_step & ~any_load;
    assign wrap_evt = step_taken & (counter_core == COUNT_TOP);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        if (wr_lport) begin
            next_counter = wdata_in;
        end else if (load_strobe | ext_load) begin
            next_counter = reload_capture_value;
        end else if (cap_reset) begin
            next_counter = DATA_RESET;
        end else if (wrap_evt && opmode == ART_AUTO_RELOAD) begin
            next_counter = reload_capture_value;
        end else if (step_taken) begin
            next_counter = counter_core + 8'h01;
        end else begin
            next_counter = counter_core;
        end
    end

    // any load, including the automatic reload, restarts the prescaler
    always_comb begin
        if (any_load || (wrap_evt && opmode == ART_AUTO_RELOAD)) begin
            next_prescaler = PSC_CLEAR;
        end else if (count_tick) begin
            next_prescaler = prescaler_stage + 7'h01;
        end else begin
            next_prescaler = prescaler_stage;
        end
    end

    assign match_evt = step_taken & (next_counter == compare_value);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            counter_core <= DATA_RESET;
            prescaler_stage <= PSC_CLEAR;
        end else if (clk_en_in) begin
            counter_core <= next_counter;
            prescaler_stage <= next_prescaler;
        end
    end

    // ------------------------------------------------------------
    // waveform pin
    // ------------------------------------------------------------
    // a match in the wrap cycle wins, giving a zero duty when reload equals compare
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pwm_level <= 1'b0;
        end else if (clk_en_in) begin
            if (match_evt) begin
                pwm_level <= 1'b0;
            end else if (wrap_evt) begin
                pwm_level <= 1'b1;
            end
        end
    end

    assign timer_output_pin_out = pwm_level;
    assign timer_output_pin_oe_out = mode_control[MC_PWM_OE];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_control <= MODE_RESET;
        end else if (wr_mode) begin
            mode_control <= wdata_in[6:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_edge_prescale_config <= CFG_RESET;
        end else if (wr_cfg) begin
            clock_edge_prescale_config <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            compare_value <= DATA_RESET;
        end else if (wr_compare) begin
            compare_value <= wdata_in;
        end
    end

    // a capture in the same cycle as a software write takes precedence
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reload_capture_value <= DATA_RESET;
        end else if (capture) begin
            reload_capture_value <= counter_core;
        end else if (wr_reload) begin
            reload_capture_value <= wdata_in;
        end
    end

    // hardware set beats a same-cycle software clear
    always_comb begin
        next_flags = wr_flags ? (event_flags & wdata_in[2:0]) : event_flags;
        next_flags = next_flags | {ext_edge, match_evt, wrap_evt};
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            event_flags <= FLAGS_RESET;
        end else if (clk_en_in) begin
            event_flags <= next_flags;
        end
    end

    assign edge_irq_out = mode_control[MC_EDGE_IE] & event_flags[FL_EDGE];
    assign match_irq_out = mode_control[MC_MATCH_IE] & event_flags[FL_MATCH];
    assign wrap_irq_out = mode_control[MC_WRAP_IE] & event_flags[FL_WRAP];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= DATA_RESET;
        end else if (clk_en_in) begin
            rdata_out <= DATA_RESET;
            if (rd_in) begin
                unique case (addr_in)
                    ADDR_MODE: rdata_out <= {1'b0, mode_control};
                    ADDR_FLAGS: rdata_out <= {5'h00, event_flags};
                    ADDR_CFG: rdata_out <= clock_edge_prescale_config;
                    ADDR_RELOAD: rdata_out <= reload_capture_value;
                    ADDR_COMPARE: rdata_out <= compare_value;
                    ADDR_LOAD_PORT: rdata_out <= counter_core;
                    default: rdata_out <= DATA_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    logic [6:0] wd_low;
    assign wd_low = wdata_in[6:0];

    sequence s_wr_mode;
        clk_en_in && wr_in && addr_in == ADDR_MODE;
    endsequence

    sequence s_rd_mode;
        clk_en_in && rd_in && addr_in == ADDR_MODE;
    endsequence

    property p_mode_readback;
        s_wr_mode ##1 !wr_in ##1 s_rd_mode |=> rdata_out == {1'b0, $past(wd_low, 3)};
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode register read back wrong");

    property p_strobe_load;
        load_strobe && !wr_lport && !ext_load |=>
            counter_core == $past(reload_capture_value) && prescaler_stage == PSC_CLEAR;
    endproperty
    a_strobe_load: assert property (p_strobe_load)
        else $error("load strobe did not load counter");

    property p_freeze;
        clk_en_in && !mode_control[MC_COUNT_EN] && !any_load |=>
            $stable(counter_core) && $stable(prescaler_stage);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counter moved while disabled");

    property p_wrap_flag;
        clk_en_in && step_taken && counter_core == COUNT_TOP |=> event_flags[FL_WRAP];
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("wrap flag not set on rollover");

    property p_clear_06;
        clk_en_in && wr_flags && wdata_in == 8'h06 && !wrap_evt |=>
            !event_flags[FL_WRAP] && (event_flags[FL_EDGE] || !$past(event_flags[FL_EDGE]));
    endproperty
    a_clear_06: assert property (p_clear_06)
        else $error("wrap clear disturbed edge flag");

    property p_capture;
        clk_en_in && capture |=> reload_capture_value == $past(counter_core);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture value wrong");

    property p_cap_reset;
        cap_reset && !wr_lport && !load_strobe |=>
            counter_core == DATA_RESET && prescaler_stage == PSC_CLEAR;
    endproperty
    a_cap_reset: assert property (p_cap_reset)
        else $error("capture reset did not clear counter");

    property p_no_src;
        clk_en_in && src_sel == ART_SRC_NONE && !any_load |=> $stable(counter_core);
    endproperty
    a_no_src: assert property (p_no_src)
        else $error("counter moved with reserved source");

    property p_edge_irq;
        clk_en_in && ext_edge && mode_control[MC_EDGE_IE] && !wr_mode |=> edge_irq_out;
    endproperty
    a_edge_irq: assert property (p_edge_irq)
        else $error("edge request missing");

    property p_pwm_oe;
        s_wr_mode ##1 1'b1 |-> timer_output_pin_oe_out == $past(wdata_in[MC_PWM_OE]);
    endproperty
    a_pwm_oe: assert property (p_pwm_oe)
        else $error("output enable not following register");
endmodule

//--- verif/art_pin_source.sv
// model of the external event source and of the load on the waveform pin
`timescale 1ns/10ps
module art_pin_source (
    // clock
    input wire logic mclk_in,
    // timer input pin side
    output logic pin_out,
    // waveform pin side
    input wire logic level_in,
    input wire logic oe_in,
    output logic [7:0] rises_out
);
    logic level_q;

    initial begin
        pin_out = 1'b0;
        rises_out = 8'h00;
        level_q = 1'b0;
    end

    // levels are held four cycles so the synchroniser never misses one
    task automatic set_level(input logic v);
        @(posedge mclk_in);
        pin_out <= v;
        repeat (4) @(posedge mclk_in);
    endtask

    task automatic pulse(input logic idle);
        set_level(~idle);
        set_level(idle);
    endtask

    // the load only sees the waveform while the pin is driven
    always @(posedge mclk_in) begin
        level_q <= level_in;
        if (oe_in && level_in && !level_q) begin
            rises_out <= rises_out + 8'h01;
        end
    end
endmodule

//--- verif/testbench.sv
// self-checking bench for the auto-reload timer
`timescale 1ns/10ps
module testbench;
    import art_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] rdata_out;
    logic pin, out_pin, out_oe, edge_irq, match_irq, wrap_irq;
    logic [7:0] rises;
    int n_mismatch = 0;
    int compares = 0;

    always #10 mclk_in = ~mclk_in;

    art_timer DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .timer_input_pin_in(pin), .timer_output_pin_out(out_pin),
        .timer_output_pin_oe_out(out_oe), .edge_irq_out(edge_irq),
        .match_irq_out(match_irq), .wrap_irq_out(wrap_irq));

    art_pin_source SRC (.mclk_in(mclk_in), .pin_out(pin), .level_in(out_pin),
        .oe_in(out_oe), .rises_out(rises));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        // let the write settle so callers see the updated registers
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp, what);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk({5'h00, edge_irq, match_irq, wrap_irq}, 8'h00, "requests after reset");
        rchk(ADDR_MODE, 8'h00, "mode reset");
        rchk(ADDR_FLAGS, 8'h00, "flags reset");
        rchk(ADDR_CFG, 8'h00, "config reset");
        wr(ADDR_CFG, 8'h10);
        rchk(ADDR_CFG, 8'h10, "reserved config bit");
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_MODE, 8'hA3);
        rchk(ADDR_MODE, 8'h23, "load strobe reads zero");
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_FLAGS, 8'hFF);
        rchk(ADDR_FLAGS, 8'h00, "ones keep flags, high bits zero");
        rchk(8'hD8, 8'h00, "unmapped address");
        wr(ADDR_LOAD_PORT, 8'hA5);
        rchk(ADDR_LOAD_PORT, 8'hA5, "load port");
        wr(ADDR_RELOAD, 8'h3C);
        wr(ADDR_MODE, 8'h80);
        rchk(ADDR_LOAD_PORT, 8'h3C, "strobe loads reload value");
        rchk(ADDR_LOAD_PORT, 8'h3C, "disabled counter holds");
        $display("test regs done");
    endtask

    task automatic t_wrap();
        int i;
        wr(ADDR_RELOAD, 8'hFC);
        wr(ADDR_COMPARE, 8'hFE);
        wr(ADDR_MODE, 8'hEC);
        for (i = 0; i < 40 && wrap_irq !== 1'b1; i++) @(posedge mclk_in);
        if (wrap_irq !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: no wrap request", $time);
            end_of_test();
        end
        wr(ADDR_MODE, 8'h2C);
        chk({7'h00, match_irq}, 8'h01, "match request");
        chk({7'h00, out_pin}, 8'h00, "match clears waveform pin");
        rchk(ADDR_FLAGS, 8'h03, "wrap and match flags");
        chk({7'h00, out_oe}, 8'h01, "waveform enabled");
        chk({7'h00, rises > 8'h00}, 8'h01, "waveform toggles");
        @(posedge mclk_in);
        #1;
        chk({7'h00, rdata_out == 8'h00}, 8'h01, "read data stands one cycle");
        rchk(ADDR_LOAD_PORT, 8'hFF, "reload then count") ;
        wr(ADDR_FLAGS, 8'h06);
        rchk(ADDR_FLAGS, 8'h02, "06h clears only wrap");
        chk({7'h00, wrap_irq}, 8'h00, "wrap request gone");
        wr(ADDR_MODE, 8'h24);
        chk({7'h00, match_irq}, 8'h00, "match request masked");
        wr(ADDR_FLAGS, 8'h00);
        wr(ADDR_MODE, 8'h00);
        chk({7'h00, out_oe}, 8'h00, "waveform disabled");
        $display("test wrap done");
    endtask

    task automatic one_edge(input logic [7:0] mode, cfg, input logic idle,
            input logic [7:0] d9, db, e9, edb, input logic ef);
        SRC.set_level(idle);
        wr(ADDR_CFG, cfg);
        wr(ADDR_RELOAD, d9);
        wr(ADDR_LOAD_PORT, db);
        wr(ADDR_MODE, 8'h10 | mode);
        SRC.pulse(idle);
        rchk(ADDR_RELOAD, e9, "reload after edge");
        rchk(ADDR_LOAD_PORT, edb, "counter after edge");
        chk({7'h00, edge_irq}, {7'h00, ef}, "edge request");
        rchk(ADDR_FLAGS, {5'h00, ef, 2'h0}, "edge flag");
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_FLAGS, 8'h00);
    endtask

    task automatic t_edges();
        // counting stays off while the edge and clock settings change
        one_edge(8'h01, 8'h04, 1'b0, 8'h11, 8'h5A, 8'h5A, 8'h5A, 1'b1);
        one_edge(8'h02, 8'h0C, 1'b1, 8'h11, 8'h6B, 8'h6B, 8'h00, 1'b1);
        one_edge(8'h03, 8'h04, 1'b0, 8'h33, 8'h77, 8'h33, 8'h33, 1'b1);
        one_edge(8'h01, 8'h08, 1'b0, 8'h11, 8'h44, 8'h11, 8'h44, 1'b0);
        $display("test edges done");
    endtask

    task automatic one_rate(input logic [7:0] cfg, input int n, lo, hi);
        logic [7:0] v;
        wr(ADDR_CFG, cfg);
        wr(ADDR_LOAD_PORT, 8'h00);
        wr(ADDR_MODE, 8'h40);
        repeat (n) @(posedge mclk_in);
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_LOAD_PORT, v);
        chk({7'h00, v >= lo[7:0] && v <= hi[7:0]}, 8'h01, "count in range");
    endtask

    task automatic t_rates();
        one_rate(8'h00, 40, 40, 44);
        one_rate(8'h40, 40, 9, 12);
        one_rate(8'h01, 30, 9, 12);
        one_rate(8'h03, 40, 0, 0);
        $display("test rates done");
    endtask

    task automatic t_pin_clock();
        SRC.set_level(1'b0);
        wr(ADDR_CFG, 8'h02);
        wr(ADDR_LOAD_PORT, 8'h00);
        wr(ADDR_MODE, 8'h40);
        repeat (5) SRC.pulse(1'b0);
        wr(ADDR_MODE, 8'h00);
        rchk(ADDR_LOAD_PORT, 8'h05, "pin edges counted");
        $display("test pin clock done");
    endtask

    // strobes made while the enable is low must leave the counter and the mode register alone
    task automatic t_hold();
        wr(ADDR_LOAD_PORT, 8'h21);
        @(posedge mclk_in);
        clk_en <= 1'b0;
        wr(ADDR_LOAD_PORT, 8'h77);
        wr(ADDR_MODE, 8'h40);
        @(posedge mclk_in);
        clk_en <= 1'b1;
        rchk(ADDR_LOAD_PORT, 8'h21, "enable low ignores load port");
        rchk(ADDR_MODE, 8'h00, "enable low ignores mode write");
        $display("test hold done");
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_wrap();
        t_edges();
        t_rates();
        t_pin_clock();
        t_hold();
        end_of_test();
    end

    initial begin
        #1ms;
        n_mismatch++;
        $display("Error at %0t: run hung", $time);
        end_of_test();
    end
endmodule
